// file: common/hpm_defines.vh
// Notes on behaviour
// - 32-bit host: all 32 data lines are taken in and driven out.
// - 16-bit host: upper 16 lines ignored on input, driven zero.
// - 8-bit host: upper 24 lines ignored on input, driven zero.
// - first read: ready drops, address latched, word fetched, piece out.
// - later reads of the same word come from the fetched copy.
// - write: ready high when able, piece latched on strobe release.
// - last piece completes the word, then the internal write occurs.
// - outstanding internal write with full queue holds ready low.
// - partial-packing status is nonzero while a word is half built.
// - 8-bit host needs four cycles per 32-bit word.
// - 32-bit host: two instructions in three transfers, order fixed.
// - 16-bit host: three transfers per instruction, order selectable.
// - 8-bit host: six byte transfers per instruction, order selectable.
// - eight message registers shared by host and core.
// - host write of vector register raises high-priority interrupt.
// - servicing pushes status stack, return pops it.
// - low 24 bits give routine address, upper 8 are data.
// - reset loads the vector register with its standard address.
// - interrupt request appears six cycles after the write.
// - a new write while pending replaces the pending address.
// - pending bit set on write, cleared on return.
// - host write during service is ignored.
// - order selector: clear low part first, set high part first.
`ifndef HPM_DEFINES_VH
`define HPM_DEFINES_VH
`define HPM_ADDR_CFG     4'h0
`define HPM_ADDR_STAT    4'h1
`define HPM_ADDR_VEC     4'h2
`define HPM_ADDR_FIFO    4'h3
`define HPM_MSG_BIT      3
`define HPM_CFG_RESET    32'h00000020
`define HPM_CFG_WID_HI   5
`define HPM_CFG_WID_LO   4
`define HPM_CFG_ORDER    6
`define HPM_CFG_FLUSH    7
`define HPM_CFG_PACK48   10
`define HPM_STAT_WPEND   12
`define HPM_STAT_VPEND   13
`define HPM_STAT_PART    14
`define HPM_W32          2'h0
`define HPM_W16          2'h1
`define HPM_VEC_RESET    32'h00000040
`define HPM_VEC_LATENCY  3'h6
`endif

// file: sim/hpm_buffer_model.sv
`timescale 1ns/1ps
// ****
// buffer side model
// ****
module hpm_buffer_model (
    input  wire        clk,
    input  wire        rst,
    input  wire        stall,
    input  wire [47:0] wr_word,
    input  wire        wr_valid,
    output wire        wr_ready,
    input  wire        rd_req,
    output reg  [47:0] rd_word,
    output reg         rd_valid
);
    logic [47:0] got [$];
    integer      wait_reg;
    assign wr_ready = !stall;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 0;
            rd_valid <= 1'b0;
            rd_word <= 48'h0;
        end else begin
            if (wr_valid && wr_ready) begin
                got.push_back(wr_word);
            end
            // idle data toggles so stale values never match
            rd_valid <= (wait_reg == 1);
            rd_word <= (wait_reg == 1) ? 48'h123456789ABC : ~rd_word;
            if (rd_req) begin
                wait_reg <= 3;
            end else if (wait_reg > 0) begin
                wait_reg <= wait_reg - 1;
            end
        end
    end
endmodule // hpm_buffer_model

// file: sim/hpm_host_port_properties.sv
`timescale 1ns/1ps
// ****
// host port checks
// ****
module hpm_properties (
    input wire        CLOCK,
    input wire        RST,
    input wire        CS_N,
    input wire        RD_N,
    input wire        WR_N,
    input wire        DATA_OE_N,
    input wire        HOST_READY_OUT,
    input wire [47:0] FIFO_WR_WORD,
    input wire        FIFO_WR_VALID,
    input wire        FIFO_WR_READY,
    input wire        FIFO_RD_REQ,
    input wire        VIRQ_REQ,
    input wire        VIRQ_ACK,
    input wire        RETURN_FROM_IRQ,
    input wire        STATUS_PUSH,
    input wire        STATUS_POP
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_serve; VIRQ_REQ && VIRQ_ACK; endsequence
    sequence s_push; ##[1:2] STATUS_PUSH; endsequence
    property p_ready_fall;
        $fell(RD_N && WR_N) && !CS_N |-> HOST_READY_OUT ##1 HOST_READY_OUT;
    endproperty
    property p_ready_idle; CS_N [*4] |-> HOST_READY_OUT; endproperty
    property p_oe_idle; RD_N [*5] |-> DATA_OE_N; endproperty
    property p_oe_wr; !WR_N [*3] |-> DATA_OE_N; endproperty
    property p_rd_pulse; FIFO_RD_REQ |=> !FIFO_RD_REQ; endproperty
    property p_wr_hold;
        FIFO_WR_VALID && !FIFO_WR_READY |=>
            FIFO_WR_VALID && $stable(FIFO_WR_WORD);
    endproperty
    property p_req_hold; VIRQ_REQ && !VIRQ_ACK |=> VIRQ_REQ; endproperty
    property p_req_drop; s_serve |-> ##[1:2] !VIRQ_REQ; endproperty
    property p_push; s_serve |-> s_push; endproperty
    property p_pop; RETURN_FROM_IRQ |-> ##[1:2] STATUS_POP; endproperty
    property p_one; STATUS_PUSH || STATUS_POP |=> !STATUS_PUSH; endproperty
    a_ready_fall: assert property (p_ready_fall)
        else $error("ready fell too early");
    a_ready_idle: assert property (p_ready_idle)
        else $error("ready low while idle");
    a_oe_idle: assert property (p_oe_idle)
        else $error("data driven without read");
    a_oe_wr: assert property (p_oe_wr)
        else $error("data driven during write");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("buffer request too long");
    a_wr_hold: assert property (p_wr_hold)
        else $error("queued word lost");
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped early");
    a_req_drop: assert property (p_req_drop)
        else $error("request kept after service");
    a_push: assert property (p_push)
        else $error("no push on service");
    a_pop: assert property (p_pop)
        else $error("no pop on return");
    a_one: assert property (p_one)
        else $error("push pulse too long");
endmodule // hpm_properties

// file: sim/tb.sv
`timescale 1ns/1ps
`include "hpm_defines.vh"
`define CHK(n_, e_, s_) begin checked++; if ((s_) !== (e_)) begin \
    mismatches++; $display("[FAIL] %s expected %0h seen %0h", n_, e_, s_); \
    end end
// ****
// bench
// ****
module tb;
    reg          CLOCK = 1'b0;
    reg          RST = 1'b1;
    reg          CS_N = 1'b1;
    reg          RD_N = 1'b1;
    reg          WR_N = 1'b1;
    reg  [3:0]   ADDR = 4'h0;
    reg  [31:0]  DATA_IN = 32'h0;
    reg  [3:0]   CORE_ADDR = 4'h0;
    reg          CORE_WE = 1'b0;
    reg  [31:0]  CORE_WDATA = 32'h0;
    reg          VIRQ_ACK = 1'b0;
    reg          RETURN_FROM_IRQ = 1'b0;
    reg          stall = 1'b0;
    wire [31:0]  DATA_OUT, CORE_RDATA;
    wire [47:0]  FIFO_WR_WORD, FIFO_RD_WORD;
    wire [23:0]  VIRQ_TARGET;
    wire         DATA_OE_N, HOST_READY_OUT, FIFO_WR_VALID, FIFO_WR_READY;
    wire         FIFO_RD_REQ, FIFO_RD_VALID, VIRQ_REQ, STATUS_PUSH;
    wire         STATUS_POP;
    integer      mismatches = 0, checked = 0, cfg, i, j, lat;
    logic [31:0] seed = 32'd48053, v, v2, q;
    logic [31:0] msg [0:7];
    logic [47:0] g, w1, w2;
    logic [47:0] exp_q [$];
    localparam logic [31:0] CFGS [0:4] = '{32'h20, 32'h60, 32'h50,
                                           32'h10, 32'h00};
    always #20 CLOCK = ~CLOCK;
    hpm_host_port hpm_host_port_inst (.CLOCK(CLOCK), .RST(RST),
        .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
        .HOST_READY_OUT(HOST_READY_OUT), .FIFO_WR_WORD(FIFO_WR_WORD),
        .FIFO_WR_VALID(FIFO_WR_VALID), .FIFO_WR_READY(FIFO_WR_READY),
        .FIFO_RD_REQ(FIFO_RD_REQ), .FIFO_RD_WORD(FIFO_RD_WORD),
        .FIFO_RD_VALID(FIFO_RD_VALID), .CORE_ADDR(CORE_ADDR),
        .CORE_WE(CORE_WE), .CORE_WDATA(CORE_WDATA),
        .CORE_RDATA(CORE_RDATA), .VIRQ_REQ(VIRQ_REQ),
        .VIRQ_TARGET(VIRQ_TARGET), .VIRQ_ACK(VIRQ_ACK),
        .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .STATUS_PUSH(STATUS_PUSH),
        .STATUS_POP(STATUS_POP));
    hpm_buffer_model hpm_buffer_model_inst (.clk(CLOCK), .rst(RST),
        .stall(stall), .wr_word(FIFO_WR_WORD), .wr_valid(FIFO_WR_VALID),
        .wr_ready(FIFO_WR_READY), .rd_req(FIFO_RD_REQ),
        .rd_word(FIFO_RD_WORD), .rd_valid(FIFO_RD_VALID));
    task stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(40 * 60000);
        mismatches++;
        stop_test;
    end
    function automatic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        rnd = seed;
    endfunction
    task automatic tick(input integer n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task core_rd(input [3:0] a, output [31:0] d);
        CORE_ADDR = a;
        tick(2);
        d = CORE_RDATA;
    endtask
    // one host cycle, held until ready is sampled high
    task cyc(input rd, input [3:0] a, input [31:0] d, output [31:0] r);
        integer n;
        n = 0;
        CS_N = 1'b0;
        ADDR = a;
        DATA_IN = d;
        RD_N = !rd;
        WR_N = rd;
        while (HOST_READY_OUT !== 1'b0 && n < 20) begin tick(1); n++; end
        while (HOST_READY_OUT !== 1'b1 && n < 300) begin tick(1); n++; end
        if (n >= 300) begin mismatches++; stop_test; end
        tick(1);
        r = DATA_OUT;
        `CHK("oe", !rd, DATA_OE_N)
        RD_N = 1'b1;
        WR_N = 1'b1;
        CS_N = 1'b1;
        tick(5);
    endtask
    // one whole packed word per call, never interleaved
    task xfer(input rd, input [3:0] a, input [47:0] w, input integer nb,
              input integer n, output [47:0] got);
        integer k, sh;
        logic [31:0] m, r, s;
        got = 48'h0;
        m = (nb == 32) ? 32'hFFFFFFFF : (32'h1 << nb) - 1;
        for (k = 0; k < n; k++) begin
            sh = cfg[`HPM_CFG_ORDER] ? (n - 1 - k) * nb : k * nb;
            cyc(rd, a, (32'(w >> sh) & m) | (rnd() & ~m), r);
            if (rd) `CHK("upper", 32'h0, r & ~m)
            got = got | (48'(r & m) << sh);
            core_rd(`HPM_ADDR_STAT, s);
            `CHK("part", k < n - 1, s[`HPM_STAT_PART])
        end
    endtask
    function integer nbits;
        nbits = cfg[5:4] == `HPM_W32 ? 32 : cfg[5:4] == `HPM_W16 ? 16 : 8;
    endfunction
    task reg_wr(input [3:0] a, input [31:0] d);
        xfer(1'b0, a, 48'(d), nbits(), 32 / nbits(), g);
        if (a == `HPM_ADDR_CFG) cfg = d & ~32'h80;
    endtask
    task reg_rd(input [3:0] a, output [31:0] d);
        xfer(1'b1, a, 48'h0, nbits(), 32 / nbits(), g);
        d = g[31:0];
    endtask
    initial begin
        tick(2);
        RST = 1'b0;
        cfg = `HPM_CFG_RESET;
        reg_rd(`HPM_ADDR_VEC, v);
        `CHK("vec reset", `HPM_VEC_RESET, v)
        `CHK("target", 24'(`HPM_VEC_RESET), VIRQ_TARGET)
        for (i = 0; i < 5; i++) begin
            reg_wr(`HPM_ADDR_CFG, CFGS[i]);
            reg_rd(`HPM_ADDR_CFG, v);
            `CHK("cfg", cfg, v)
            for (j = 0; j < 8; j++) begin msg[j] = rnd(); reg_wr(8 + j, msg[j]); end
            for (j = 0; j < 8; j++) begin
                reg_rd(8 + j, v);
                `CHK("msg", msg[j], v)
            end
        end
        CORE_WDATA = rnd();
        CORE_ADDR = 4'hB;
        CORE_WE = 1'b1;
        tick(1);
        CORE_WE = 1'b0;
        reg_rd(4'hB, v);
        `CHK("core msg", CORE_WDATA, v)
        core_rd(4'h8, v);
        `CHK("host msg", msg[0], v)
        v = rnd();
        reg_wr(`HPM_ADDR_VEC, v);
        lat = 0;
        while (VIRQ_REQ !== 1'b1 && lat < 30) begin tick(1); lat++; end
        `CHK("latency", 1, lat)
        `CHK("target", v[23:0], VIRQ_TARGET)
        core_rd(`HPM_ADDR_STAT, q);
        `CHK("pending", 1'b1, q[`HPM_STAT_VPEND])
        v2 = rnd();
        reg_wr(`HPM_ADDR_VEC, v2);
        tick(10);
        `CHK("replace", v2[23:0], VIRQ_TARGET)
        reg_rd(`HPM_ADDR_VEC, q);
        `CHK("vec data", v2, q)
        VIRQ_ACK = 1'b1;
        tick(1);
        VIRQ_ACK = 1'b0;
        reg_wr(`HPM_ADDR_VEC, rnd());
        tick(10);
        `CHK("no irq", 1'b0, VIRQ_REQ)
        `CHK("kept", v2[23:0], VIRQ_TARGET)
        RETURN_FROM_IRQ = 1'b1;
        tick(1);
        RETURN_FROM_IRQ = 1'b0;
        core_rd(`HPM_ADDR_STAT, q);
        `CHK("cleared", 1'b0, q[`HPM_STAT_VPEND])
        reg_wr(`HPM_ADDR_CFG, 32'h440);
        w1 = 48'({rnd(), rnd()});
        w2 = 48'({rnd(), rnd()});
        exp_q.push_back(w1);
        exp_q.push_back(w2);
        stall = 1'b1;
        fork begin tick(60); stall = 1'b0; end join_none
        // fixed order, even count needs no dummy
        cyc(1'b0, `HPM_ADDR_FIFO, w1[47:16], q);
        cyc(1'b0, `HPM_ADDR_FIFO, {w2[15:0], w1[15:0]}, q);
        cyc(1'b0, `HPM_ADDR_FIFO, w2[47:16], q);
        reg_wr(`HPM_ADDR_CFG, 32'h450);
        xfer(1'b1, `HPM_ADDR_FIFO, 48'h0, 16, 3, g);
        `CHK("rd48", 48'h123456789ABC, g)
        reg_wr(`HPM_ADDR_CFG, 32'h420);
        cyc(1'b0, `HPM_ADDR_FIFO, rnd(), q);
        CORE_WDATA = 32'h000004A0;
        CORE_ADDR = 4'h0;
        CORE_WE = 1'b1;
        tick(1);
        CORE_WE = 1'b0;
        core_rd(`HPM_ADDR_STAT, q);
        `CHK("flush", 1'b0, q[`HPM_STAT_PART])
        w1 = 48'({rnd(), rnd()});
        exp_q.push_back(w1);
        xfer(1'b0, `HPM_ADDR_FIFO, w1, 8, 6, g);
        tick(10);
        `CHK("count", 3, hpm_buffer_model_inst.got.size())
        for (i = 0; i < 3; i++)
            `CHK("wr48", exp_q[i], hpm_buffer_model_inst.got[i])
        stop_test;
    end
endmodule // tb
bind hpm_host_port hpm_properties hpm_properties_inst (.CLOCK(CLOCK),
    .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
    .DATA_OE_N(DATA_OE_N), .HOST_READY_OUT(HOST_READY_OUT),
    .FIFO_WR_WORD(FIFO_WR_WORD), .FIFO_WR_VALID(FIFO_WR_VALID),
    .FIFO_WR_READY(FIFO_WR_READY), .FIFO_RD_REQ(FIFO_RD_REQ),
    .VIRQ_REQ(VIRQ_REQ), .VIRQ_ACK(VIRQ_ACK),
    .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .STATUS_PUSH(STATUS_PUSH),
    .STATUS_POP(STATUS_POP));

// file: src/hpm_host_port.v
`timescale 1ns/1ps
`include "hpm_defines.vh"
module hpm_host_port (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        CS_N,
    input  wire        RD_N,
    input  wire        WR_N,
    input  wire [3:0]  ADDR,
    input  wire [31:0] DATA_IN,
    output wire [31:0] DATA_OUT,
    output wire        DATA_OE_N,
    output wire        HOST_READY_OUT,
    output wire [47:0] FIFO_WR_WORD,
    output wire        FIFO_WR_VALID,
    input  wire        FIFO_WR_READY,
    output wire        FIFO_RD_REQ,
    input  wire [47:0] FIFO_RD_WORD,
    input  wire        FIFO_RD_VALID,
    input  wire [3:0]  CORE_ADDR,
    input  wire        CORE_WE,
    input  wire [31:0] CORE_WDATA,
    output wire [31:0] CORE_RDATA,
    output wire        VIRQ_REQ,
    output wire [23:0] VIRQ_TARGET,
    input  wire        VIRQ_ACK,
    input  wire        RETURN_FROM_IRQ,
    output wire        STATUS_PUSH,
    output wire        STATUS_POP
);
    // ***************************************************
    // states and helpers
    // ***************************************************
    localparam S_IDLE  = 6'h01;
    localparam S_FETCH = 6'h02;
    localparam S_LOAD  = 6'h04;
    localparam S_RDOUT = 6'h08;
    localparam S_WRACC = 6'h10;
    localparam S_WAIT  = 6'h20;

    function [2:0] npieces;
        input [1:0] w;
        input       p48;
        begin
            case (w)
                `HPM_W32: npieces = p48 ? 3'h3 : 3'h1;
                `HPM_W16: npieces = p48 ? 3'h3 : 3'h2;
                default:  npieces = p48 ? 3'h6 : 3'h4;
            endcase
        end
    endfunction

    function [31:0] wmask;
        input [1:0] w;
        begin
            case (w)
                `HPM_W32: wmask = 32'hFFFFFFFF;
                `HPM_W16: wmask = 32'h0000FFFF;
                default:  wmask = 32'h000000FF;
            endcase
        end
    endfunction

    function [6:0] poff;
        input [2:0] c;
        input [1:0] w;
        input       msw;
        input       p48;
        reg   [6:0] pw;
        reg   [6:0] tot;
        begin
            pw  = (w == `HPM_W32) ? 7'h20 : (w == `HPM_W16) ? 7'h10 : 7'h08;
            tot = p48 ? 7'h30 : 7'h20;
            poff = msw ? (tot - ({4'h0, c} + 7'h01) * pw)
                       : ({4'h0, c} * pw);
        end
    endfunction

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    reg        cs1_reg, cs2_reg, rd1_reg, rd2_reg, wr1_reg, wr2_reg;
    reg [3:0]  a1_reg, a2_reg;
    reg [31:0] d1_reg, d2_reg;
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cs1_reg <= 1'b0;
            cs2_reg <= 1'b0;
            rd1_reg <= 1'b0;
            rd2_reg <= 1'b0;
            wr1_reg <= 1'b0;
            wr2_reg <= 1'b0;
            a1_reg  <= 4'h0;
            a2_reg  <= 4'h0;
            d1_reg  <= 32'h00000000;
            d2_reg  <= 32'h00000000;
        end else begin
            cs1_reg <= ~CS_N;
            cs2_reg <= cs1_reg;
            rd1_reg <= ~RD_N;
            rd2_reg <= rd1_reg;
            wr1_reg <= ~WR_N;
            wr2_reg <= wr1_reg;
            a1_reg  <= ADDR;
            a2_reg  <= a1_reg;
            d1_reg  <= DATA_IN;
            d2_reg  <= d1_reg;
        end
    end

    // ***************************************************
    // state registers
    // ***************************************************
    reg [5:0]  state_reg, state_next;
    reg [31:0] cfg_reg, vec_reg;
    reg [95:0] buf_reg, buf_next;
    reg [2:0]  cnt_reg, cnt_next;
    reg [3:0]  addr_reg;
    reg        ph_reg;
    reg        wq_valid_reg;
    reg [47:0] wq_word_reg;
    reg [31:0] dout_reg;
    reg        oe_n_reg;
    reg        vpend_reg, vserv_reg;
    reg [2:0]  vlat_reg;
    reg        push_reg, pop_reg;
    reg [31:0] core_rd_reg;
    reg        core_msg_reg;

    wire [31:0] mem_host_rd, mem_core_rd;
    wire [1:0]  width  = cfg_reg[`HPM_CFG_WID_HI:`HPM_CFG_WID_LO];
    wire        msw    = cfg_reg[`HPM_CFG_ORDER];
    wire        tfifo  = (addr_reg == `HPM_ADDR_FIFO);
    wire        tmsg   = addr_reg[`HPM_MSG_BIT];
    wire        p48    = cfg_reg[`HPM_CFG_PACK48] & tfifo;
    wire        w3248  = p48 & (width == `HPM_W32);
    wire [2:0]  last   = npieces(width, p48) - 3'h1;
    wire [6:0]  off    = poff(cnt_reg, width, msw, p48);
    wire [31:0] mask   = wmask(width);
    wire [31:0] din    = d2_reg & mask;
    wire        access = cs2_reg & (rd2_reg | wr2_reg);
    // only first piece, or second word of a pair, fetches
    wire need_fetch = (cnt_reg == 3'h0) | (w3248 & (cnt_reg == 3'h1));
    wire wr_done  = (state_reg == S_WRACC) & ~wr2_reg;
    wire wr_final = wr_done & (cnt_reg == last);
    wire wr_emit  = wr_done & tfifo & ((cnt_reg == last) |
                    (w3248 & (cnt_reg == 3'h1)));
    wire host_reg_we = wr_final & ~tfifo;
    wire vec_host_we = host_reg_we & (addr_reg == `HPM_ADDR_VEC);
    wire core_cfg = CORE_WE & (CORE_ADDR == `HPM_ADDR_CFG);
    wire flush = host_reg_we & (addr_reg == `HPM_ADDR_CFG) &
                 buf_next[`HPM_CFG_FLUSH] |
                 core_cfg & CORE_WDATA[`HPM_CFG_FLUSH];
    wire [31:0] status = {17'h0, (cnt_reg != 3'h0), vpend_reg,
                          wq_valid_reg, 12'h0};

    reg [31:0] reg_rd;
    always @* begin
        case (addr_reg)
            `HPM_ADDR_CFG:  reg_rd = cfg_reg;
            `HPM_ADDR_STAT: reg_rd = status;
            `HPM_ADDR_VEC:  reg_rd = vec_reg;
            default:        reg_rd = tmsg ? mem_host_rd : 32'h00000000;
        endcase
    end

    // ***************************************************
    // packing datapath
    // ***************************************************
    reg [31:0] piece;
    reg [47:0] emit;
    reg [95:0] shifted;
    always @* begin
        shifted  = buf_reg >> off;
        buf_next = buf_reg;
        piece    = 32'h00000000;
        emit     = {16'h0000, buf_reg[31:0]};
        if (w3248) begin
            // word1 hi, split middle, word2 hi
            case (cnt_reg)
                3'h0: piece = buf_reg[47:16];
                3'h1: piece = {buf_reg[63:48], buf_reg[15:0]};
                default: piece = buf_reg[95:64];
            endcase
        end else begin
            piece = shifted[31:0] & mask;
        end
        if (state_reg == S_FETCH && ph_reg) begin
            if (tfifo && w3248 && cnt_reg == 3'h1) begin
                buf_next[95:48] = FIFO_RD_WORD;
            end else if (tfifo) begin
                buf_next[47:0] = p48 ? FIFO_RD_WORD
                                     : {16'h0000, FIFO_RD_WORD[31:0]};
            end else begin
                buf_next[47:0] = {16'h0000, reg_rd};
            end
        end
        if (wr_done) begin
            if (w3248) begin
                case (cnt_reg)
                    3'h0: buf_next[47:16] = din;
                    3'h1: begin
                        buf_next[63:48] = din[31:16];
                        buf_next[15:0]  = din[15:0];
                    end
                    default: buf_next[95:64] = din;
                endcase
            end else begin
                buf_next = (buf_reg & ~({64'h0, mask} << off)) |
                           ({64'h0, din} << off);
            end
        end
        if (w3248) begin
            emit = (cnt_reg == 3'h1) ? buf_next[47:0] : buf_next[95:48];
        end else if (p48) begin
            emit = buf_next[47:0];
        end else begin
            emit = {16'h0000, buf_next[31:0]};
        end
    end

    // ***************************************************
    // host cycle sequencer
    // ***************************************************
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            S_IDLE: begin
                // ready drops as the access starts
                if (access && rd2_reg) begin
                    state_next = need_fetch ? S_FETCH : S_LOAD;
                end else if (access && !wq_valid_reg) begin
                    // full queue holds the write off
                    state_next = S_WRACC;
                end
            end
            S_FETCH: begin
                if (ph_reg && (!tfifo || FIFO_RD_VALID)) begin
                    state_next = S_LOAD;
                end
            end
            S_LOAD: state_next = S_RDOUT;
            S_RDOUT: begin
                if (!rd2_reg) begin
                    cnt_next   = (cnt_reg == last) ? 3'h0 : cnt_reg + 3'h1;
                    state_next = S_IDLE;
                end
            end
            S_WRACC: begin
                if (!wr2_reg) begin
                    cnt_next   = (cnt_reg == last) ? 3'h0 : cnt_reg + 3'h1;
                    state_next = S_WAIT;
                end
            end
            S_WAIT: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
        if (flush) begin
            cnt_next = 3'h0;
        end
    end

    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_reg    <= S_IDLE;
            cnt_reg      <= 3'h0;
            buf_reg      <= 96'h0;
            addr_reg     <= 4'h0;
            ph_reg       <= 1'b0;
            dout_reg     <= 32'h00000000;
            oe_n_reg     <= 1'b1;
            wq_valid_reg <= 1'b0;
            wq_word_reg  <= 48'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            buf_reg   <= buf_next;
            ph_reg    <= (state_reg == S_FETCH) & ~(state_next == S_LOAD);
            if (state_reg == S_IDLE && access) begin
                addr_reg <= a2_reg;
            end
            if (state_reg == S_LOAD) begin
                dout_reg <= piece & mask;
                oe_n_reg <= 1'b0;
            end else if (state_reg != S_RDOUT || !rd2_reg) begin
                oe_n_reg <= 1'b1;
            end
            // completed word written to its target
            if (wr_emit) begin
                wq_valid_reg <= 1'b1;
                wq_word_reg  <= emit;
            end else if (FIFO_WR_READY) begin
                wq_valid_reg <= 1'b0;
            end
        end
    end

    // ***************************************************
    // config and vector interrupt
    // ***************************************************
    wire core_vec = CORE_WE & (CORE_ADDR == `HPM_ADDR_VEC);
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cfg_reg   <= `HPM_CFG_RESET;
            vec_reg   <= `HPM_VEC_RESET;
            vpend_reg <= 1'b0;
            vserv_reg <= 1'b0;
            vlat_reg  <= 3'h0;
            push_reg  <= 1'b0;
            pop_reg   <= 1'b0;
        end else begin
            push_reg <= 1'b0;
            pop_reg  <= 1'b0;
            if (host_reg_we && addr_reg == `HPM_ADDR_CFG) begin
                cfg_reg <= buf_next[31:0] & ~(32'h1 << `HPM_CFG_FLUSH);
            end else if (core_cfg) begin
                cfg_reg <= CORE_WDATA & ~(32'h1 << `HPM_CFG_FLUSH);
            end
            if (vec_host_we && !vserv_reg) begin
                vec_reg   <= buf_next[31:0];
                vpend_reg <= 1'b1;
            end else if (core_vec) begin
                vec_reg <= CORE_WDATA;
            end
            // six-cycle latency, kept running on rewrite
            if (vec_host_we && !vserv_reg && !vpend_reg) begin
                vlat_reg <= `HPM_VEC_LATENCY - 3'h1;
            end else if (vlat_reg != 3'h0) begin
                vlat_reg <= vlat_reg - 3'h1;
            end
            // push on service entry, even during a host write
            if (VIRQ_REQ && VIRQ_ACK) begin
                vserv_reg <= 1'b1;
                push_reg  <= 1'b1;
            end else if (vserv_reg && RETURN_FROM_IRQ) begin
                vserv_reg <= 1'b0;
                vpend_reg <= 1'b0;
                pop_reg   <= 1'b1;
            end
        end
    end

    // ***************************************************
    // message registers and core read
    // ***************************************************
    // eight shared message registers
    hpm_msg_mem u_msg (
        .clk     (CLOCK),
        .a_we    (host_reg_we & tmsg),
        .a_addr  (addr_reg[2:0]),
        .a_wdata (buf_next[31:0]),
        .a_rdata (mem_host_rd),
        .b_we    (CORE_WE & CORE_ADDR[`HPM_MSG_BIT]),
        .b_addr  (CORE_ADDR[2:0]),
        .b_wdata (CORE_WDATA),
        .b_rdata (mem_core_rd)
    );

    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            core_rd_reg  <= 32'h00000000;
            core_msg_reg <= 1'b0;
        end else begin
            core_msg_reg <= CORE_ADDR[`HPM_MSG_BIT];
            case (CORE_ADDR)
                `HPM_ADDR_CFG:  core_rd_reg <= cfg_reg;
                `HPM_ADDR_STAT: core_rd_reg <= status;
                `HPM_ADDR_VEC:  core_rd_reg <= vec_reg;
                default:        core_rd_reg <= 32'h00000000;
            endcase
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    // ready low while an access is held, except in S_RDOUT and S_WRACC
    assign HOST_READY_OUT = ~access | (state_reg == S_RDOUT) |
                            (state_reg == S_WRACC);
    assign DATA_OUT      = dout_reg;
    assign DATA_OE_N     = oe_n_reg;
    assign FIFO_WR_WORD  = wq_word_reg;
    assign FIFO_WR_VALID = wq_valid_reg;
    assign FIFO_RD_REQ   = (state_reg == S_FETCH) & ~ph_reg & tfifo;
    assign CORE_RDATA    = core_msg_reg ? mem_core_rd : core_rd_reg;
    assign VIRQ_REQ      = vpend_reg & ~vserv_reg & (vlat_reg == 3'h0);
    // low 24 bits are the routine address
    assign VIRQ_TARGET   = vec_reg[23:0];
    assign STATUS_PUSH   = push_reg;
    assign STATUS_POP    = pop_reg;
endmodule // hpm_host_port

// file: src/hpm_msg_mem.v
`timescale 1ns/1ps
module hpm_msg_mem (
    input  wire        clk,
    input  wire        a_we,
    input  wire [2:0]  a_addr,
    input  wire [31:0] a_wdata,
    output reg  [31:0] a_rdata,
    input  wire        b_we,
    input  wire [2:0]  b_addr,
    input  wire [31:0] b_wdata,
    output reg  [31:0] b_rdata
);
    reg [31:0] mem [0:7];

    // host port written last so it wins a same-word collision
    always @(posedge clk) begin
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule // hpm_msg_mem
